// [logic/lpa_target.sv]
// Target end: address match, command pointer and register file
`timescale 1ns/1ps
// Behaviour
// - Master sends address right after start
// - Address byte bit zero: one reads
// - Broadcast address 90h enabled from reset
// - Master never uses 90h as regular
// - Subgroups 92h 94h 98h, disabled at reset
// - Soft reset call acknowledged only writing
// - Soft reset address never programmed anywhere; the master checks this only on the first data byte
// - First write byte stored as command pointer
// - Pointer bits 4:0, mode bits 7:5
// - Top mode bit steps pointer every byte
// - Mode 000 keeps pointer fixed
// - Mode 100 wraps 11h to 00h
// - Mode 101 wraps 09h to 02h
// - Mode 110 wraps 0Bh to 0Ah
// - Mode 111 wraps 0Bh to 02h
// - Master never writes modes 001-011
// - Sequences skip current reference, error flags
// - Increment touches pointer bits only
// - First access uses written pointer
// - Register map 00h to 13h
// - Mode one bits 3:0 enable addresses
// - Mode one bits 7:5 mirror mode
module lpa_target #(
   parameter logic [2:0] HW_PREFIX = lpa_pkg::HW_PREFIX_DEF,
   parameter logic [6:0] SOFT_RESET_ADDR = lpa_pkg::SOFT_RESET_ADDR_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link
   lpa_link_if.dev lk,
   // Device side
   input wire logic [3:0] hw_addr,
   input wire logic [7:0] error_flag_reg,
   output logic [lpa_pkg::NUM_STORED*8-1:0] reg_image,
   output logic [2:0] incr_mode_field,
   output logic soft_reset_call
);
   import lpa_pkg::*;

   typedef struct packed {
      lpa_dst_t st;
      logic [7:0] command_pointer;
      logic [NUM_STORED-1:0][7:0] regs;
      logic ans_vld;
      logic ans_ack;
      logic [7:0] ans_byte;
      logic soft_rst;
   } lpa_dev_s_t;

   lpa_dev_s_t s_r;
   lpa_dev_s_t s_nxt;

   // Pointer step with per mode wrap
   function automatic logic [4:0] lpa_next_ptr(input logic [4:0] p,
                                               input logic [2:0] m);
      logic [4:0] f;
      logic [4:0] l;
      f = REG_MODE_ONE;
      l = REG_BCAST;
      unique case (m)
         INC_ALL: begin
            f = REG_MODE_ONE;
            l = REG_BCAST;
         end
         INC_BRT: begin
            f = REG_BRT_FIRST;
            l = REG_BRT_LAST;
         end
         INC_GCTL: begin
            f = REG_GDUTY;
            l = REG_GFREQ;
         end
         INC_BOTH: begin
            f = REG_BRT_FIRST;
            l = REG_GFREQ;
         end
         default: ;
      endcase
      if (!m[2]) begin
         lpa_next_ptr = p;
      end else if (p == l) begin
         lpa_next_ptr = f;
      end else if (p >= REG_BCAST) begin
         // Outside the window the pointer runs on to 11h; from 11h or above it goes to 00h
         lpa_next_ptr = REG_MODE_ONE;
      end else begin
         lpa_next_ptr = 5'(p + 5'h01);
      end
   endfunction

   // Register read with live mode mirror
   function automatic logic [7:0] lpa_read(input lpa_dev_s_t s,
                                           input logic [4:0] p,
                                           input logic [7:0] ef);
      if (p == REG_MODE_ONE) begin
         lpa_read = {s.command_pointer[7:CTRL_MODE_LSB],
                     s.regs[REG_MODE_ONE][M1_KEEP_MSB:0]};
      end else if (p == REG_ERR_FLAG) begin
         // Error flags are read live from the device side
         lpa_read = ef;
      end else if (p < REG_ERR_FLAG) begin
         lpa_read = s.regs[p];
      end else begin
         lpa_read = 8'h00;
      end
   endfunction

   // Decoded fields of the incoming byte and the pointer
   logic [6:0] a7;
   logic rw;
   logic hit;
   logic [4:0] ptr;
   logic [2:0] mode;
   logic [7:0] m1;

   always_comb begin
      a7 = lk.op_byte[7:1];
      rw = lk.op_byte[0];
      ptr = s_r.command_pointer[CTRL_PTR_MSB:0];
      mode = s_r.command_pointer[7:CTRL_MODE_LSB];
      m1 = s_r.regs[REG_MODE_ONE];
      // Pin address, then broadcast and subgroups, each when enabled, on bits 7:1
      hit = (a7 == {HW_PREFIX, hw_addr})
         | (m1[M1_BCAST_EN] && a7 == s_r.regs[REG_BCAST][7:1])
         | (m1[M1_GRP1_EN] && a7 == s_r.regs[REG_GRP1][7:1])
         | (m1[M1_GRP2_EN] && a7 == s_r.regs[REG_GRP2][7:1])
         | (m1[M1_GRP3_EN] && a7 == s_r.regs[REG_GRP3][7:1]);
      s_nxt = s_r;
      s_nxt.ans_vld = 1'b0;
      s_nxt.soft_rst = 1'b0;
      if (lk.op_vld) begin
         s_nxt.ans_vld = 1'b1;
         s_nxt.ans_ack = 1'b0;
         s_nxt.ans_byte = 8'h00;
         unique case (lk.op)
            LPA_OP_START: s_nxt.st = D_ADDR;
            LPA_OP_STOP: s_nxt.st = D_IDLE;
            LPA_OP_ADDR: begin
               if (s_r.st == D_ADDR) begin
                  s_nxt.st = D_SKIP;
                  if (a7 == SOFT_RESET_ADDR) begin
                     s_nxt.ans_ack = !rw;
                     s_nxt.soft_rst = !rw;
                  end else if (hit) begin
                     s_nxt.ans_ack = 1'b1;
                     s_nxt.st = rw ? D_RDATA : D_CTRL;
                  end
               end
            end
            LPA_OP_WRITE: begin
               if (s_r.st == D_CTRL) begin
                  s_nxt.command_pointer = lk.op_byte;
                  s_nxt.ans_ack = 1'b1;
                  s_nxt.st = D_WDATA;
               end else if (s_r.st == D_WDATA) begin
                  s_nxt.ans_ack = 1'b1;
                  if (ptr == REG_MODE_ONE) begin
                     // Mode bits 7:5 of this register only mirror
                     s_nxt.regs[REG_MODE_ONE] =
                        {3'h0, lk.op_byte[M1_KEEP_MSB:0]};
                  end else if (ptr < REG_ERR_FLAG) begin
                     s_nxt.regs[ptr] = lk.op_byte;
                  end
                  s_nxt.command_pointer[CTRL_PTR_MSB:0] =
                     lpa_next_ptr(ptr, mode);
               end
            end
            LPA_OP_READ: begin
               if (s_r.st == D_RDATA) begin
                  s_nxt.ans_ack = 1'b1;
                  s_nxt.ans_byte = lpa_read(s_r, ptr, error_flag_reg);
                  s_nxt.command_pointer[CTRL_PTR_MSB:0] =
                     lpa_next_ptr(ptr, mode);
               end
            end
            default: ;
         endcase
      end
   end

   // State flops; reset loads the power-up register values
   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.st <= D_IDLE;
         s_r.regs[REG_MODE_ONE] <= MODE_ONE_RST;
         s_r.regs[REG_GRP1] <= GRP1_RST;
         s_r.regs[REG_GRP2] <= GRP2_RST;
         s_r.regs[REG_GRP3] <= GRP3_RST;
         s_r.regs[REG_BCAST] <= BCAST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs come straight from the state flops
   assign lk.ans_vld = s_r.ans_vld;
   assign lk.ans_ack = s_r.ans_ack;
   assign lk.ans_byte = s_r.ans_byte;
   assign reg_image = s_r.regs;
   assign incr_mode_field = s_r.command_pointer[7:CTRL_MODE_LSB];
   assign soft_reset_call = s_r.soft_rst;
endmodule

// [logic/lpa_pkg.sv]
// Shared constants and types for the address match and pointer link
package lpa_pkg;
   // Register indices
   localparam logic [4:0] REG_MODE_ONE = 5'h00;
   localparam logic [4:0] REG_BRT_FIRST = 5'h02;
   localparam logic [4:0] REG_BRT_LAST = 5'h09;
   localparam logic [4:0] REG_GDUTY = 5'h0A;
   localparam logic [4:0] REG_GFREQ = 5'h0B;
   localparam logic [4:0] REG_GRP1 = 5'h0E;
   localparam logic [4:0] REG_GRP2 = 5'h0F;
   localparam logic [4:0] REG_GRP3 = 5'h10;
   localparam logic [4:0] REG_BCAST = 5'h11;
   localparam logic [4:0] REG_CUR_REF = 5'h12;
   localparam logic [4:0] REG_ERR_FLAG = 5'h13;
   localparam int NUM_STORED = 19;
   // Reset values
   localparam logic [7:0] MODE_ONE_RST = 8'h11;
   localparam logic [7:0] GRP1_RST = 8'h92;
   localparam logic [7:0] GRP2_RST = 8'h94;
   localparam logic [7:0] GRP3_RST = 8'h98;
   localparam logic [7:0] BCAST_RST = 8'h90;
   // Address figure defaults
   localparam logic [2:0] HW_PREFIX_DEF = 3'h4;
   localparam logic [6:0] SOFT_RESET_ADDR_DEF = 7'h6B;
   // Field positions
   localparam int CTRL_PTR_MSB = 4;
   localparam int CTRL_MODE_LSB = 5;
   localparam int M1_BCAST_EN = 0;
   localparam int M1_GRP3_EN = 1;
   localparam int M1_GRP2_EN = 2;
   localparam int M1_GRP1_EN = 3;
   localparam int M1_KEEP_MSB = 4;
   // Increment modes
   localparam logic [2:0] INC_ALL = 3'h4;
   localparam logic [2:0] INC_BRT = 3'h5;
   localparam logic [2:0] INC_GCTL = 3'h6;
   localparam logic [2:0] INC_BOTH = 3'h7;
   typedef enum logic [2:0] {
      LPA_OP_START, LPA_OP_STOP, LPA_OP_ADDR, LPA_OP_WRITE, LPA_OP_READ
   } lpa_op_t;
   typedef enum logic [2:0] {
      D_IDLE, D_ADDR, D_CTRL, D_WDATA, D_RDATA, D_SKIP
   } lpa_dst_t;
   typedef enum logic [0:0] {H_IDLE, H_WAIT} lpa_hst_t;
   typedef enum logic [2:0] {
      P_FREE, P_ADDR_DUE, P_CTRL_DUE, P_FIRST_DATA, P_DATA, P_READ, P_DEAD
   } lpa_phase_t;
endpackage

// [logic/lpa_link_if.sv]
// Byte level link between bus master end and target end
`timescale 1ns/1ps
interface lpa_link_if (
   input wire logic clk,
   input wire logic reset
);
   import lpa_pkg::*;
   logic op_vld;
   lpa_op_t op;
   logic [7:0] op_byte;
   logic ans_vld;
   logic ans_ack;
   logic [7:0] ans_byte;
   modport host (output op_vld, op, op_byte, input ans_vld, ans_ack, ans_byte);
   modport dev (input op_vld, op, op_byte, output ans_vld, ans_ack, ans_byte);
endinterface

// [logic/lpa_master.sv]
// Bus master end: sequences link operations and guards illegal ones
`timescale 1ns/1ps
module lpa_master #(
   parameter logic [6:0] SOFT_RESET_ADDR = lpa_pkg::SOFT_RESET_ADDR_DEF
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link
   lpa_link_if.host lk,
   // Command
   input wire logic cmd_vld,
   output logic cmd_rdy,
   input wire lpa_pkg::lpa_op_t cmd_op,
   input wire logic [7:0] cmd_byte,
   input wire logic cmd_group,
   // Result
   output logic res_vld,
   output logic res_ack,
   output logic res_err,
   output logic [7:0] res_byte
);
   import lpa_pkg::*;

   typedef struct packed {
      lpa_hst_t st;
      lpa_phase_t ph;
      logic [7:0] ctrl;
      logic op_vld;
      lpa_op_t op;
      logic [7:0] op_byte;
      logic res_vld;
      logic res_ack;
      logic res_err;
      logic [7:0] res_byte;
   } lpa_hst_s_t;

   lpa_hst_s_t s_r;
   lpa_hst_s_t s_nxt;
   logic bad;
   logic wr_ok;
   logic addr_reg;

   always_comb begin
      wr_ok = (s_r.ph == P_CTRL_DUE) || (s_r.ph == P_FIRST_DATA)
         || (s_r.ph == P_DATA);
      addr_reg = (s_r.ctrl[4:0] >= REG_GRP1) && (s_r.ctrl[4:0] <= REG_BCAST);
      bad = 1'b0;
      unique case (cmd_op)
         LPA_OP_ADDR: bad = (s_r.ph != P_ADDR_DUE)
            || (!cmd_group && cmd_byte[7:1] == BCAST_RST[7:1])
            || (!cmd_group && cmd_byte[7:1] == SOFT_RESET_ADDR);
         LPA_OP_WRITE: bad = !wr_ok
            || (s_r.ph == P_CTRL_DUE && cmd_byte[7]
                == 1'b0 && cmd_byte[6:5] != 2'h0)
            || (s_r.ph == P_FIRST_DATA && addr_reg
                && cmd_byte[7:1] == SOFT_RESET_ADDR);
         LPA_OP_READ: bad = (s_r.ph != P_READ);
         default: bad = 1'b0;
      endcase
      s_nxt = s_r;
      s_nxt.op_vld = 1'b0;
      s_nxt.res_vld = 1'b0;
      if (s_r.st == H_IDLE && cmd_vld) begin
         if (bad) begin
            s_nxt.res_vld = 1'b1;
            s_nxt.res_err = 1'b1;
            s_nxt.res_ack = 1'b0;
            s_nxt.res_byte = 8'h00;
         end else begin
            s_nxt.op_vld = 1'b1;
            s_nxt.op = cmd_op;
            s_nxt.op_byte = cmd_byte;
            s_nxt.st = H_WAIT;
         end
      end else if (s_r.st == H_WAIT && lk.ans_vld) begin
         s_nxt.st = H_IDLE;
         s_nxt.res_vld = 1'b1;
         s_nxt.res_err = 1'b0;
         s_nxt.res_ack = lk.ans_ack;
         s_nxt.res_byte = lk.ans_byte;
         unique case (s_r.op)
            LPA_OP_START: s_nxt.ph = P_ADDR_DUE;
            LPA_OP_STOP: s_nxt.ph = P_FREE;
            LPA_OP_ADDR: begin
               if (!lk.ans_ack) begin
                  s_nxt.ph = P_DEAD;
               end else begin
                  s_nxt.ph = s_r.op_byte[0] ? P_READ : P_CTRL_DUE;
               end
            end
            LPA_OP_WRITE: begin
               if (!lk.ans_ack) begin
                  s_nxt.ph = P_DEAD;
               end else if (s_r.ph == P_CTRL_DUE) begin
                  s_nxt.ctrl = s_r.op_byte;
                  s_nxt.ph = P_FIRST_DATA;
               end else begin
                  s_nxt.ph = P_DATA;
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s_r <= '0;
         s_r.st <= H_IDLE;
         s_r.ph <= P_FREE;
         s_r.op <= LPA_OP_START;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cmd_rdy = (s_r.st == H_IDLE);
   assign lk.op_vld = s_r.op_vld;
   assign lk.op = s_r.op;
   assign lk.op_byte = s_r.op_byte;
   assign res_vld = s_r.res_vld;
   assign res_ack = s_r.res_ack;
   assign res_err = s_r.res_err;
   assign res_byte = s_r.res_byte;
endmodule

// [testbench/lpa_link_props.sv]
// Link checker for the address match and pointer link
`timescale 1ns/1ps
module lpa_link_props (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Link
   input wire logic op_vld,
   input wire lpa_pkg::lpa_op_t op,
   input wire logic [7:0] op_byte,
   input wire logic ans_vld,
   input wire logic ans_ack,
   input wire logic [7:0] ans_byte
);
   import lpa_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic ad;
   assign ad = op_vld && op == LPA_OP_ADDR;
   a_answer_next: assert property (op_vld |=> ans_vld)
      else $error("answer missing");
   a_no_stray: assert property (ans_vld |-> $past(op_vld))
      else $error("answer without request");
   a_start_nack: assert property (op_vld && op == LPA_OP_START |=> !ans_ack)
      else $error("start acknowledged");
   a_stop_nack: assert property (op_vld && op == LPA_OP_STOP |=> !ans_ack)
      else $error("stop acknowledged");
   a_bcast_ack: assert property (
      ad && op_byte[7:1] == BCAST_RST[7:1] |=> ans_ack)
      else $error("broadcast not acknowledged");
   a_soft_rst_read: assert property (
      ad && op_byte == {SOFT_RESET_ADDR_DEF, 1'b1} |=> ans_vld && !ans_ack)
      else $error("soft reset read acknowledged");
   a_soft_rst_write: assert property (
      ad && op_byte == {SOFT_RESET_ADDR_DEF, 1'b0} |=> ans_ack)
      else $error("soft reset write not acknowledged");
   a_group_off: assert property (ad && (op_byte[7:1] == GRP1_RST[7:1]
      || op_byte[7:1] == GRP2_RST[7:1] || op_byte[7:1] == GRP3_RST[7:1])
      |=> !ans_ack)
      else $error("disabled subgroup acknowledged");
   a_byte_hold: assert property (!ans_vld |-> $stable(ans_byte))
      else $error("answer byte moved");
   c_bcast: cover property (ad && op_byte == BCAST_RST ##1 ans_ack);
   c_soft_rst: cover property (
      ad && op_byte[7:1] == SOFT_RESET_ADDR_DEF ##1 ans_ack);
   c_read: cover property (op_vld && op == LPA_OP_READ ##1 ans_vld);
endmodule

// [testbench/tb_top.sv]
// Testbench joining master and target ends over the link
`timescale 1ns/1ps
module tb_top;
   import lpa_pkg::*;
   logic clk, reset, cmd_vld, cmd_group, cmd_rdy;
   lpa_op_t cmd_op;
   logic [7:0] cmd_byte, res_byte, error_flag_reg, r_byte;
   logic res_vld, res_ack, res_err, r_ack, r_err, soft_reset_call;
   logic [3:0] hw_addr;
   logic [NUM_STORED*8-1:0] reg_image;
   logic [2:0] incr_mode_field;
   int errors = 0;
   int samples_checked = 0;
   int soft_rst_cnt = 0;
   localparam logic [7:0] MY_W = 8'h8A;
   localparam logic [7:0] MY_R = 8'h8B;
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   lpa_link_if lpa_link_if_inst (.clk(clk), .reset(reset));
   lpa_master lpa_master_inst (.clk(clk), .reset(reset),
      .lk(lpa_link_if_inst), .cmd_vld(cmd_vld), .cmd_rdy(cmd_rdy),
      .cmd_op(cmd_op), .cmd_byte(cmd_byte), .cmd_group(cmd_group),
      .res_vld(res_vld), .res_ack(res_ack), .res_err(res_err),
      .res_byte(res_byte));
   lpa_target lpa_target_inst (.clk(clk), .reset(reset),
      .lk(lpa_link_if_inst), .hw_addr(hw_addr),
      .error_flag_reg(error_flag_reg), .reg_image(reg_image),
      .incr_mode_field(incr_mode_field),
      .soft_reset_call(soft_reset_call));
   lpa_link_props lpa_link_props_inst (.clk(clk), .reset(reset),
      .op_vld(lpa_link_if_inst.op_vld), .op(lpa_link_if_inst.op),
      .op_byte(lpa_link_if_inst.op_byte),
      .ans_vld(lpa_link_if_inst.ans_vld),
      .ans_ack(lpa_link_if_inst.ans_ack),
      .ans_byte(lpa_link_if_inst.ans_byte));
   always @(posedge clk) begin
      if (soft_reset_call === 1'b1) soft_rst_cnt <= soft_rst_cnt + 1;
   end
   function automatic logic [7:0] rg(input int n);
      return reg_image[8*n +: 8];
   endfunction
   task complete_run;
      if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] s,
                        input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One command through the master, entered and left at a falling edge
   task automatic send(input lpa_op_t o, input logic [7:0] b,
                       input logic g);
      int i;
      logic taken;
      @(negedge clk);
      cmd_op = o;
      cmd_byte = b;
      cmd_group = g;
      cmd_vld = 1'b1;
      for (i = 0; i < 20; i++) begin
         taken = cmd_rdy;
         @(negedge clk);
         if (taken === 1'b1) cmd_vld = 1'b0;
         if (res_vld === 1'b1) break;
      end
      r_ack = res_ack;
      r_err = res_err;
      r_byte = res_byte;
      if (i == 20) begin
         errors++;
         complete_run();
      end
   endtask
   task automatic ack(input lpa_op_t o, input logic [7:0] b,
                      input logic g, input logic a);
      send(o, b, g);
      check("ack", {7'h00, r_ack}, {7'h00, a});
   endtask
   task automatic err(input lpa_op_t o, input logic [7:0] b, input logic g);
      send(o, b, g);
      check("refused", {7'h00, r_err}, 8'h01);
   endtask
   task automatic t_reset_values;
      check("ready", {7'h00, cmd_rdy}, 8'h01);
      check("mode_one", rg(0), MODE_ONE_RST);
      check("grp1", rg(14), GRP1_RST);
      check("grp2", rg(15), GRP2_RST);
      check("grp3", rg(16), GRP3_RST);
      check("bcast", rg(17), BCAST_RST);
      check("mode", {5'h00, incr_mode_field}, 8'h00);
   endtask
   task automatic t_bcast;
      send(LPA_OP_START, 8'h00, 1'b0);
      ack(LPA_OP_ADDR, 8'h90, 1'b1, 1'b1);
      ack(LPA_OP_WRITE, 8'h91, 1'b0, 1'b1);
      send(LPA_OP_WRITE, 8'h90, 1'b0);
      send(LPA_OP_WRITE, 8'h01, 1'b0);
      send(LPA_OP_WRITE, 8'h5A, 1'b0);
      send(LPA_OP_STOP, 8'h00, 1'b0);
      check("bcast", rg(17), 8'h90);
      check("mode_one", rg(0), 8'h01);
      check("mode2", rg(1), 8'h5A);
      check("mode", {5'h00, incr_mode_field}, 8'h04);
   endtask
   task automatic t_modes;
      logic [2:0] md [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
      int p [4] = '{3, 9, 11, 11};
      int w [4] = '{3, 2, 10, 2};
      for (int k = 0; k < 4; k++) begin
         send(LPA_OP_START, 8'h00, 1'b0);
         ack(LPA_OP_ADDR, MY_W, 1'b0, 1'b1);
         send(LPA_OP_WRITE, {md[k], p[k][4:0]}, 1'b0);
         send(LPA_OP_WRITE, 8'hA0 + 8'(k), 1'b0);
         send(LPA_OP_WRITE, 8'hB0 + 8'(k), 1'b0);
         send(LPA_OP_STOP, 8'h00, 1'b0);
         check("first", rg(p[k]), 8'(k) + (k == 0 ? 8'hB0 : 8'hA0));
         check("wrap", rg(w[k]), 8'hB0 + 8'(k));
         check("mode", {5'h00, incr_mode_field}, {5'h00, md[k]});
      end
   endtask
   task automatic rd_at(input logic [7:0] c, input logic [7:0] e0,
                        input logic [7:0] e1);
      send(LPA_OP_START, 8'h00, 1'b0);
      send(LPA_OP_ADDR, MY_W, 1'b0);
      send(LPA_OP_WRITE, c, 1'b0);
      send(LPA_OP_START, 8'h00, 1'b0);
      ack(LPA_OP_ADDR, MY_R, 1'b0, 1'b1);
      send(LPA_OP_READ, 8'h00, 1'b0);
      check("read0", r_byte, e0);
      send(LPA_OP_READ, 8'h00, 1'b0);
      check("read1", r_byte, e1);
      send(LPA_OP_STOP, 8'h00, 1'b0);
   endtask
   task automatic t_soft_rst;
      int n;
      n = soft_rst_cnt;
      send(LPA_OP_START, 8'h00, 1'b0);
      ack(LPA_OP_ADDR, {SOFT_RESET_ADDR_DEF, 1'b1}, 1'b1, 1'b0);
      send(LPA_OP_START, 8'h00, 1'b0);
      ack(LPA_OP_ADDR, {SOFT_RESET_ADDR_DEF, 1'b0}, 1'b1, 1'b1);
      send(LPA_OP_STOP, 8'h00, 1'b0);
      check("soft_rst", 8'(soft_rst_cnt - n), 8'h01);
   endtask
   task automatic t_group_off;
      logic [7:0] b [3] = '{8'h92, 8'h95, 8'h98};
      for (int k = 0; k < 3; k++) begin
         send(LPA_OP_START, 8'h00, 1'b0);
         ack(LPA_OP_ADDR, b[k], 1'b1, 1'b0);
         send(LPA_OP_STOP, 8'h00, 1'b0);
      end
   endtask
   task automatic t_refused;
      send(LPA_OP_START, 8'h00, 1'b0);
      send(LPA_OP_ADDR, MY_W, 1'b0);
      for (int c = 1; c < 4; c++) begin
         err(LPA_OP_WRITE, {c[2:0], 5'h02}, 1'b0);
      end
      send(LPA_OP_WRITE, 8'h0E, 1'b0);
      err(LPA_OP_WRITE, {SOFT_RESET_ADDR_DEF, 1'b0}, 1'b0);
      send(LPA_OP_STOP, 8'h00, 1'b0);
      send(LPA_OP_START, 8'h00, 1'b0);
      err(LPA_OP_ADDR, 8'h90, 1'b0);
      err(LPA_OP_ADDR, {SOFT_RESET_ADDR_DEF, 1'b0}, 1'b0);
      send(LPA_OP_STOP, 8'h00, 1'b0);
      check("grp1", rg(14), GRP1_RST);
   endtask
   initial begin
      cmd_vld = 1'b0;
      cmd_op = LPA_OP_START;
      cmd_byte = 8'h00;
      cmd_group = 1'b0;
      hw_addr = 4'h5;
      error_flag_reg = 8'hC3;
      reset = 1'b1;
      repeat (16) @(negedge clk);
      reset = 1'b0;
      t_reset_values();
      t_bcast();
      t_modes();
      rd_at(8'h13, 8'hC3, 8'hC3);
      rd_at(8'h92, 8'h00, 8'h81);
      rd_at(8'hF1, 8'h90, 8'hE1);
      t_soft_rst();
      t_group_off();
      t_refused();
      complete_run();
   end
endmodule
